// ---- eqsp_pkg.sv ----
`default_nettype none
package eqsp_pkg;
	localparam int addr_width = 7;
	localparam int data_width = 8;
	localparam int frame_bits = 16;
	localparam int cmd_bits = 8;
	localparam int reg_count = 5;
	localparam logic [6:0] general_control_offset = 7'h00;
	localparam logic [6:0] output_driver_setup_offset = 7'h01;
	localparam logic [6:0] launch_amplitude_trim_offset = 7'h02;
	localparam logic [6:0] cable_length_readout_offset = 7'h03;
	localparam logic [6:0] spare_offset = 7'h04;
	localparam int carrier_bit = 7;
	localparam int mute_bit = 6;
	localparam int bypass_bit = 5;
	localparam int sleep_lsb = 3;
	localparam int ext_reach_bit = 2;
	localparam int swing_lsb = 5;
	localparam int offset_lsb = 2;
	localparam int coarse_bit = 7;
	localparam int fine_lsb = 3;
	localparam int cable_lsb = 3;
	localparam logic [7:0] general_control_reset = 8'h08;
	localparam logic [7:0] output_driver_setup_reset = 8'h64;
	localparam logic [7:0] launch_amplitude_trim_reset = 8'h00;
	localparam logic [7:0] spare_reset = 8'h00;
	localparam logic [4:0] cable_max = 5'h19;
	localparam logic [1:0] sleep_always_on = 2'h0;
	localparam logic [1:0] sleep_auto = 2'h1;
	localparam logic [1:0] sleep_forced = 2'h2;
	typedef struct packed {
		logic sel_n;
		logic sck;
		logic mosi;
	} eqsp_serial_type;
	typedef struct packed {
		logic powered_down;
		logic outputs_muted;
		logic eq_bypassed;
		logic ext_reach;
		logic [2:0] swing_code;
		logic [2:0] offset_code;
		logic coarse_half;
		logic [3:0] fine_gain;
	} eqsp_analog_ctl_type;
endpackage
`default_nettype wire

// ---- eqsp_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module eqsp_sync #(
	parameter int width = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);
	logic [width-1:0] stage1;
	logic [width-1:0] next_stage1;
	logic [width-1:0] next_sync_out;
	if (width < 1) begin : g_width_check
		$error("width too small");
	end
	always_comb begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= '1;
			sync_out <= '1;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule
`default_nettype wire

// ---- eqsp_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module eqsp_regs #(
	parameter int depth = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [6:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [6:0] rd_addr,
	input wire logic carrier_present,
	input wire logic [4:0] cable_length_estimate,
	output logic [7:0] rd_data,
	output logic [7:0] general_control,
	output logic [7:0] output_driver_setup,
	output logic [7:0] launch_amplitude_trim
);
	logic [7:0] spare;
	logic [7:0] next_general_control;
	logic [7:0] next_output_driver_setup;
	logic [7:0] next_launch_amplitude_trim;
	logic [7:0] next_spare;
	logic [7:0] next_rd_data;
	logic [7:0] live_status;
	if (depth != eqsp_pkg::reg_count) begin : g_depth_check
		$error("depth must be five");
	end
	always_comb begin
		next_general_control = general_control;
		next_output_driver_setup = output_driver_setup;
		next_launch_amplitude_trim = launch_amplitude_trim;
		next_spare = spare;
		if (wr_en) begin
			case (wr_addr)
				eqsp_pkg::general_control_offset: begin
					next_general_control = {1'b0, wr_data[6:2], 2'h0};
				end
				eqsp_pkg::output_driver_setup_offset: begin
					next_output_driver_setup = {wr_data[7:2], 2'h0};
				end
				eqsp_pkg::launch_amplitude_trim_offset: begin
					next_launch_amplitude_trim = {wr_data[7:3], 3'h0};
				end
				eqsp_pkg::spare_offset: begin
					next_spare = wr_data;
				end
				default: begin
				end
			endcase
		end
		live_status = general_control;
		live_status[eqsp_pkg::carrier_bit] = carrier_present;
		next_rd_data = rd_data;
		if (rd_en) begin
			case (rd_addr)
				eqsp_pkg::general_control_offset: next_rd_data = live_status;
				eqsp_pkg::output_driver_setup_offset: next_rd_data = output_driver_setup;
				eqsp_pkg::launch_amplitude_trim_offset: next_rd_data = launch_amplitude_trim;
				eqsp_pkg::cable_length_readout_offset: begin
					next_rd_data = {cable_length_estimate, 3'h0};
				end
				eqsp_pkg::spare_offset: next_rd_data = spare;
				default: next_rd_data = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			general_control <= eqsp_pkg::general_control_reset;
			output_driver_setup <= eqsp_pkg::output_driver_setup_reset;
			launch_amplitude_trim <= eqsp_pkg::launch_amplitude_trim_reset;
			spare <= eqsp_pkg::spare_reset;
			rd_data <= 8'h00;
		end else begin
			general_control <= next_general_control;
			output_driver_setup <= next_output_driver_setup;
			launch_amplitude_trim <= next_launch_amplitude_trim;
			spare <= next_spare;
			rd_data <= next_rd_data;
		end
	end
endmodule
`default_nettype wire

// ---- eqsp_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - serial port works only while mode select is high; else pin mode
// - five eight-bit registers reachable over the serial port
// - write frame: 0, seven address bits, eight data bits on mosi
// - mosi sampled on each rising sck edge of the command and write data bits
// - miso stays high impedance during write frames
// - read frame starts with 1 then seven address bits
// - read fetch after eighth rise; data out from eighth falling edge
// - swing code bits 7:5 of register 1, default 011
// - offset code bits 4:2 of register 1, default 001, any code up to 111 accepted
// - register 2 bit 7 coarse launch amplitude, 1 means half amplitude
// - register 2 bits 6:3 fine input gain trim
// - register 3 bits 7:3 cable length estimate, 0 to 25
// - register 0 bit 2 enables extended reach mode
// - extended reach off after reset
// - sleep field: 00 on, 01 auto, 10 forced, 11 reserved
// - register 0 bit 7 reads carrier detect state
// - sleep beats mute, mute beats bypass
// - forced sleep powers down whatever the input
module eqsp_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic mode_select,
	input wire logic sel_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic carrier_present,
	input wire logic signal_present,
	input wire logic [4:0] cable_length_estimate,
	input wire logic pin_mute,
	input wire logic pin_bypass,
	input wire logic pin_auto_sleep,
	output logic miso_out,
	output logic miso_oe_n,
	output eqsp_pkg::eqsp_analog_ctl_type analog_ctl
);
	typedef enum logic [4:0] {
		st_idle = 5'b00001,
		st_cmd = 5'b00010,
		st_wdata = 5'b00100,
		st_rdata = 5'b01000,
		st_done = 5'b10000
	} eqsp_state_type;
	function automatic logic [1:0] eqsp_edges(input logic prev, input logic cur);
		eqsp_edges = {~prev & cur, prev & ~cur};
	endfunction
	function automatic logic [7:0] eqsp_shift(input logic [7:0] word, input logic bit_in);
		eqsp_shift = {word[6:0], bit_in};
	endfunction
	eqsp_pkg::eqsp_serial_type raw_pins;
	eqsp_pkg::eqsp_serial_type pins;
	logic spi_mode;
	logic [4:0] level_pins;
	logic [4:0] level_sync;
	logic carrier_sync;
	logic signal_sync;
	logic mute_sync;
	logic bypass_sync;
	logic auto_sleep_sync;
	logic [4:0] cable_sync;
	logic [4:0] cable_prev;
	logic [4:0] next_cable_prev;
	logic [4:0] cable_stable;
	logic [4:0] next_cable_stable;
	logic sck_prev;
	logic next_sck_prev;
	logic [1:0] sck_edge;
	eqsp_state_type state;
	eqsp_state_type next_state;
	logic [3:0] bit_count;
	logic [3:0] next_bit_count;
	logic [7:0] shift_in;
	logic [7:0] next_shift_in;
	logic [6:0] addr;
	logic [6:0] next_addr;
	logic [7:0] shift_out;
	logic [7:0] next_shift_out;
	logic load_pending;
	logic next_load_pending;
	logic next_miso_out;
	logic next_miso_oe_n;
	logic wr_en;
	logic rd_en;
	logic [7:0] rd_data;
	logic [7:0] general_control;
	logic [7:0] output_driver_setup;
	logic [7:0] launch_amplitude_trim;
	logic [4:0] cable_clamped;
	logic [1:0] sleep_code;
	logic eff_mute;
	logic eff_bypass;
	logic eff_sleep_req;
	eqsp_pkg::eqsp_analog_ctl_type next_analog_ctl;
	assign raw_pins = '{sel_n: sel_n, sck: sck, mosi: mosi};
	assign level_pins = {carrier_present, signal_present, pin_mute, pin_bypass, pin_auto_sleep};
	eqsp_sync #(.width(3)) u_serial_sync (
		.clk(clk),
		.rst(rst),
		.async_in(raw_pins),
		.sync_out(pins)
	);
	eqsp_sync #(.width(1)) u_mode_sync (
		.clk(clk),
		.rst(rst),
		.async_in(mode_select),
		.sync_out(spi_mode)
	);
	// status and pin-mode levels come from the analog side, unclocked
	eqsp_sync #(.width(5)) u_level_sync (
		.clk(clk),
		.rst(rst),
		.async_in(level_pins),
		.sync_out(level_sync)
	);
	assign carrier_sync = level_sync[4];
	assign signal_sync = level_sync[3];
	assign mute_sync = level_sync[2];
	assign bypass_sync = level_sync[1];
	assign auto_sleep_sync = level_sync[0];
	// estimate bits may settle apart; a word is taken only once
	// two samples in a row agree, so a torn word never gets read
	eqsp_sync #(.width(5)) u_cable_sync (
		.clk(clk),
		.rst(rst),
		.async_in(cable_length_estimate),
		.sync_out(cable_sync)
	);
	always_comb begin
		next_cable_prev = cable_sync;
		next_cable_stable = cable_stable;
		if (cable_sync == cable_prev) begin
			next_cable_stable = cable_sync;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cable_prev <= 5'h00;
			cable_stable <= 5'h00;
		end else begin
			cable_prev <= next_cable_prev;
			cable_stable <= next_cable_stable;
		end
	end
	assign sck_edge = eqsp_edges(sck_prev, pins.sck);
	assign cable_clamped = (cable_stable > eqsp_pkg::cable_max) ?
		eqsp_pkg::cable_max : cable_stable;
	eqsp_regs #(.depth(eqsp_pkg::reg_count)) u_regs (
		.clk(clk),
		.rst(rst),
		.wr_en(wr_en),
		.wr_addr(addr),
		.wr_data(next_shift_in),
		.rd_en(rd_en),
		.rd_addr(next_addr),
		.carrier_present(carrier_sync),
		.cable_length_estimate(cable_clamped),
		.rd_data(rd_data),
		.general_control(general_control),
		.output_driver_setup(output_driver_setup),
		.launch_amplitude_trim(launch_amplitude_trim)
	);
	// serial frame engine
	always_comb begin
		next_sck_prev = pins.sck;
		next_state = state;
		next_bit_count = bit_count;
		next_shift_in = shift_in;
		next_addr = addr;
		next_shift_out = shift_out;
		next_load_pending = 1'b0;
		next_miso_out = miso_out;
		next_miso_oe_n = miso_oe_n;
		wr_en = 1'b0;
		rd_en = 1'b0;
		if (!spi_mode || pins.sel_n) begin
			next_state = st_idle;
			next_bit_count = 4'h0;
			next_miso_oe_n = 1'b1;
			next_miso_out = 1'b0;
		end else begin
			case (state)
				st_idle: begin
					next_state = st_cmd;
					next_bit_count = 4'h0;
				end
				st_cmd: begin
					if (sck_edge[1]) begin
						next_shift_in = eqsp_shift(shift_in, pins.mosi);
						next_bit_count = bit_count + 4'h1;
						if (bit_count == 4'(eqsp_pkg::cmd_bits - 1)) begin
							next_addr = next_shift_in[6:0];
							next_bit_count = 4'h0;
							if (shift_in[6]) begin
								// fetch on the new address; data ready next clock
								rd_en = 1'b1;
								next_load_pending = 1'b1;
								next_state = st_rdata;
							end else begin
								next_state = st_wdata;
							end
						end
					end
				end
				st_wdata: begin
					if (sck_edge[1]) begin
						next_shift_in = eqsp_shift(shift_in, pins.mosi);
						next_bit_count = bit_count + 4'h1;
						if (bit_count == 4'(eqsp_pkg::frame_bits - eqsp_pkg::cmd_bits - 1)) begin
							wr_en = 1'b1;
							next_state = st_done;
							next_bit_count = 4'h0;
						end
					end
				end
				st_rdata: begin
					if (load_pending) begin
						next_shift_out = rd_data;
					end
					if (sck_edge[0] && bit_count < 4'(eqsp_pkg::data_width)) begin
						next_miso_oe_n = 1'b0;
						next_miso_out = load_pending ? rd_data[7] : shift_out[7];
						next_shift_out = eqsp_shift(load_pending ? rd_data : shift_out, 1'b0);
						next_bit_count = bit_count + 4'h1;
					end
				end
				st_done: begin
					// clocks beyond the frame are ignored until select rises
					next_state = st_done;
				end
				default: begin
					next_state = st_idle;
				end
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_prev <= 1'b0;
			state <= st_idle;
			bit_count <= 4'h0;
			shift_in <= 8'h00;
			addr <= 7'h00;
			shift_out <= 8'h00;
			load_pending <= 1'b0;
			miso_out <= 1'b0;
			miso_oe_n <= 1'b1;
		end else begin
			sck_prev <= next_sck_prev;
			state <= next_state;
			bit_count <= next_bit_count;
			shift_in <= next_shift_in;
			addr <= next_addr;
			shift_out <= next_shift_out;
			load_pending <= next_load_pending;
			miso_out <= next_miso_out;
			miso_oe_n <= next_miso_oe_n;
		end
	end
	// analog control decode
	always_comb begin
		sleep_code = general_control[eqsp_pkg::sleep_lsb +: 2];
		eff_mute = spi_mode ? general_control[eqsp_pkg::mute_bit] : mute_sync;
		eff_bypass = spi_mode ? general_control[eqsp_pkg::bypass_bit] : bypass_sync;
		if (!spi_mode) begin
			eff_sleep_req = auto_sleep_sync && !signal_sync;
		end else begin
			case (sleep_code)
				eqsp_pkg::sleep_always_on: eff_sleep_req = 1'b0;
				eqsp_pkg::sleep_auto: eff_sleep_req = !signal_sync;
				eqsp_pkg::sleep_forced: eff_sleep_req = 1'b1;
				default: eff_sleep_req = 1'b0;
			endcase
		end
		next_analog_ctl.powered_down = eff_sleep_req;
		next_analog_ctl.outputs_muted = !eff_sleep_req && eff_mute;
		next_analog_ctl.eq_bypassed = !eff_sleep_req && !eff_mute && eff_bypass;
		next_analog_ctl.ext_reach = spi_mode && general_control[eqsp_pkg::ext_reach_bit];
		next_analog_ctl.swing_code = spi_mode ? output_driver_setup[eqsp_pkg::swing_lsb +: 3] :
			eqsp_pkg::output_driver_setup_reset[eqsp_pkg::swing_lsb +: 3];
		next_analog_ctl.offset_code = spi_mode ? output_driver_setup[eqsp_pkg::offset_lsb +: 3] :
			eqsp_pkg::output_driver_setup_reset[eqsp_pkg::offset_lsb +: 3];
		next_analog_ctl.coarse_half = spi_mode && launch_amplitude_trim[eqsp_pkg::coarse_bit];
		next_analog_ctl.fine_gain = spi_mode ? launch_amplitude_trim[eqsp_pkg::fine_lsb +: 4] :
			4'h0;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			analog_ctl <= '0;
		end else begin
			analog_ctl <= next_analog_ctl;
		end
	end
endmodule
`default_nettype wire

// ---- eqsp_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module eqsp_top_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic mode_select,
	input wire logic sel_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic signal_present,
	input wire logic pin_auto_sleep,
	input wire logic miso_oe_n,
	input wire eqsp_pkg::eqsp_analog_ctl_type analog_ctl
);
	// own sync of select and serial clock, bit count per frame
	logic [5:0] sy;
	logic [5:0] next_sy;
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic cmd;
	logic next_cmd;
	always_comb begin
		next_sy = {sy[3:0], sel_n, sck};
		next_cnt = cnt;
		next_cmd = cmd;
		if (rst || sy[3]) begin
			next_cnt = 5'h00;
		end else if (sy[2] && !sy[4]) begin
			next_cnt = cnt + 5'h01;
			if (cnt == 5'h00) begin
				next_cmd = mosi;
			end
		end
	end
	always_ff @(posedge clk) begin
		sy <= next_sy;
		cnt <= next_cnt;
		cmd <= next_cmd;
	end
	a_write_hi_z: assert property (@(posedge clk) disable iff (rst)
		(cnt != 5'h00 && !cmd && !sy[3]) |-> miso_oe_n) else $error("miso driven in write");
	a_read_drive: assert property (@(posedge clk) disable iff (rst)
		(sy[2] && !sy[4] && cmd && cnt == 5'h08) |-> !miso_oe_n) else $error("miso not driven");
	a_pin_hi_z: assert property (@(posedge clk) disable iff (rst)
		(!mode_select) [*6] |-> miso_oe_n) else $error("miso driven in pin mode");
	a_pin_codes: assert property (@(posedge clk) disable iff (rst)
		(!mode_select) [*6] |-> (analog_ctl.swing_code == 3'h3 && analog_ctl.offset_code == 3'h1
		&& !analog_ctl.ext_reach)) else $error("pin mode codes wrong");
	a_pin_sleep: assert property (@(posedge clk) disable iff (rst)
		(!mode_select && pin_auto_sleep && !signal_present) [*6] |-> analog_ctl.powered_down)
		else $error("pin auto sleep not taken");
	a_reset_state: assert property (@(posedge clk)
		rst |=> (analog_ctl == '0 && miso_oe_n)) else $error("reset state wrong");
	a_sleep_first: assert property (@(posedge clk) disable iff (rst)
		analog_ctl.powered_down |-> !(analog_ctl.outputs_muted || analog_ctl.eq_bypassed))
		else $error("sleep not first");
	a_mute_first: assert property (@(posedge clk) disable iff (rst)
		analog_ctl.outputs_muted |-> !analog_ctl.eq_bypassed) else $error("mute not first");
endmodule
bind eqsp_top eqsp_top_sva chk (.clk(clk), .rst(rst), .mode_select(mode_select),
	.sel_n(sel_n), .sck(sck), .mosi(mosi), .signal_present(signal_present),
	.pin_auto_sleep(pin_auto_sleep), .miso_oe_n(miso_oe_n), .analog_ctl(analog_ctl));
`default_nettype wire

// ---- eqsp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module eqsp_host #(
	parameter int half = 6,
	parameter int settle_cycles = 50000
) (
	input wire logic clk,
	output eqsp_pkg::eqsp_serial_type ser,
	input wire logic miso
);
	initial begin
		ser = '{1'b1, 1'b0, 1'b0};
	end
	// msb first; mosi released as toggling after the 8th rise of a read
	task automatic xfer(input logic [15:0] f, input int n, output logic [7:0] rd);
		rd = 8'h00;
		ser.sel_n <= 1'b0;
		repeat (half) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			if (!(f[15] && i > 7)) begin
				ser.mosi <= f[15-i];
			end
			repeat (half) @(posedge clk);
			ser.sck <= 1'b1;
			if (i > 7) begin
				rd[15-i] = miso;
			end
			@(posedge clk);
			if (f[15] && i > 6) begin
				ser.mosi <= ~ser.mosi;
			end
			repeat (half - 1) @(posedge clk);
			ser.sck <= 1'b0;
		end
		repeat (half) @(posedge clk);
		ser.sel_n <= 1'b1;
		repeat (half) @(posedge clk);
	endtask
	task automatic settle;
		repeat (settle_cycles) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk;
	logic rst;
	logic mode_select;
	logic carrier_present;
	logic signal_present;
	logic [4:0] cable_length_estimate;
	logic pin_mute;
	logic pin_bypass;
	logic pin_auto_sleep;
	logic miso_out;
	logic miso_oe_n;
	logic toggle = 1'b0;
	logic [7:0] rd;
	eqsp_pkg::eqsp_serial_type ser;
	eqsp_pkg::eqsp_analog_ctl_type analog_ctl;
	int errors;
	int n_checks;
	// scaled settle wait keeps the run short
	eqsp_host #(.half(6), .settle_cycles(2000)) host (.clk(clk), .ser(ser),
		.miso(miso_oe_n ? toggle : miso_out));
	eqsp_top DUT (.clk(clk), .rst(rst), .mode_select(mode_select), .sel_n(ser.sel_n),
		.sck(ser.sck), .mosi(ser.mosi), .carrier_present(carrier_present),
		.signal_present(signal_present), .cable_length_estimate(cable_length_estimate),
		.pin_mute(pin_mute), .pin_bypass(pin_bypass), .pin_auto_sleep(pin_auto_sleep),
		.miso_out(miso_out), .miso_oe_n(miso_oe_n), .analog_ctl(analog_ctl));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) toggle <= ~toggle;
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b0, a, d}, 16, rd);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
		host.xfer({1'b1, a, 8'h00}, 16, rd);
		chk("register", rd, exp);
	endtask
	task automatic pwr(input logic [7:0] exp);
		repeat (4) @(posedge clk);
		chk("power", {5'h00, analog_ctl.powered_down, analog_ctl.outputs_muted,
			analog_ctl.eq_bypassed}, exp);
	endtask
	task automatic report_and_stop;
		if (errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		report_and_stop;
	end
	initial begin
		errors = 0;
		n_checks = 0;
		rst = 1'b1;
		pin_bypass = 1'b0;
		mode_select = 1'b1;
		carrier_present = 1'b1;
		signal_present = 1'b1;
		cable_length_estimate = 5'h12;
		pin_mute = 1'b0;
		pin_auto_sleep = 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("ext", {7'h00, analog_ctl.ext_reach}, 8'h00);
		rdc(7'h00, 8'h88);
		rdc(7'h01, 8'h64);
		rdc(7'h02, 8'h00);
		rdc(7'h03, 8'h90);
		rdc(7'h04, 8'h00);
		wr(7'h01, 8'hff);
		rdc(7'h01, 8'hfc);
		chk("drv", {2'h0, analog_ctl.swing_code, analog_ctl.offset_code}, 8'h3f);
		wr(7'h02, 8'hff);
		rdc(7'h02, 8'hf8);
		chk("trim", {3'h0, analog_ctl.coarse_half, analog_ctl.fine_gain}, 8'h1f);
		cable_length_estimate <= 5'h1f;
		wr(7'h03, 8'h00);
		rdc(7'h03, 8'hc8);
		wr(7'h04, 8'ha5);
		rdc(7'h04, 8'ha5);
		rdc(7'h05, 8'h00);
		host.xfer({1'b0, 7'h04, 8'h3c}, 12, rd);
		rdc(7'h04, 8'ha5);
		wr(7'h00, 8'h60);
		pwr(8'h02);
		rdc(7'h00, 8'he0);
		wr(7'h00, 8'h20);
		pwr(8'h01);
		cable_length_estimate <= 5'h08;
		rdc(7'h03, 8'h40);
		wr(7'h00, 8'h10);
		pwr(8'h04);
		wr(7'h00, 8'h14);
		chk("ext", {7'h00, analog_ctl.ext_reach}, 8'h01);
		host.settle;
		wr(7'h00, 8'h0c);
		pwr(8'h00);
		signal_present <= 1'b0;
		pwr(8'h04);
		signal_present <= 1'b1;
		carrier_present <= 1'b0;
		rdc(7'h00, 8'h0c);
		wr(7'h00, 8'h14);
		wr(7'h00, 8'h10);
		chk("ext", {7'h00, analog_ctl.ext_reach}, 8'h00);
		host.settle;
		wr(7'h00, 8'h08);
		rdc(7'h00, 8'h08);
		mode_select <= 1'b0;
		pin_mute <= 1'b1;
		pin_auto_sleep <= 1'b1;
		signal_present <= 1'b0;
		wr(7'h04, 8'h11);
		pwr(8'h04);
		signal_present <= 1'b1;
		pwr(8'h02);
		pin_bypass <= 1'b1;
		pwr(8'h02);
		pin_mute <= 1'b0;
		pwr(8'h01);
		mode_select <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(7'h04, 8'ha5);
		report_and_stop;
	end
endmodule
`default_nettype wire
